// >>> logic/ckc_pkg.sv
package ckc_pkg;
   // Oscillator source selection, fixed at configuration time
   typedef enum logic [2:0] {
      CKC_SRC_XTAL_LOW  = 3'h0,
      CKC_SRC_XTAL_MED  = 3'h1,
      CKC_SRC_XTAL_HIGH = 3'h2,
      CKC_SRC_RC        = 3'h3,
      CKC_SRC_EXT       = 3'h4
   } ckc_src_t;

   // Wake-up sequencing
   typedef enum logic [1:0] {
      CKC_ST_RUN  = 2'h0,
      CKC_ST_DOWN = 2'h1,
      CKC_ST_WAIT = 2'h3
   } ckc_state_t;

   // Register byte addresses
   localparam logic [7:0] CKC_ADDR_DIVIDER = 8'h00;
   localparam logic [7:0] CKC_ADDR_PORT2M1 = 8'h04;
   localparam logic [7:0] CKC_ADDR_CONTROL = 8'h08;
   localparam logic [7:0] CKC_ADDR_STATUS  = 8'h0c;

   // Field positions
   localparam int CKC_CLKOUT_EN_BIT = 4;
   localparam int CKC_PD_BIT        = 0;
   localparam int CKC_COMPAT_BIT    = 1;

   // Reset values and write mask
   localparam logic [7:0] CKC_DIVIDER_RST = 8'h00;
   localparam logic [7:0] CKC_PORT2M1_RST = 8'h00;
   localparam logic [7:0] CKC_PORT2M1_MASK = 8'hf7;

   // Stability counts in CPU clocks and output divide ratio
   localparam int CKC_STABLE_XTAL = 1024;
   localparam int CKC_STABLE_RC   = 256;
   localparam int CKC_OUT_RATIO   = 6;
endpackage

// >>> logic/ckc_div_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ckc_div_if;
   logic       cpu_tick;
   logic       running;
   logic       clkout_en;
   logic       clkout;
   modport ctrl (output cpu_tick, output running, output clkout_en,
                 input clkout);
   modport div  (input cpu_tick, input running, input clkout_en,
                 output clkout);
endinterface
`default_nettype wire

// >>> logic/ckc_out_div.sv
`timescale 1ns/100ps
`default_nettype none
module ckc_out_div (
   // System
   input  wire logic clk,
   input  wire logic reset,
   // Divider link
   ckc_div_if.div    dl
);
   logic [2:0] phase;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase <= 3'h0;
      end else if (!dl.clkout_en || !dl.running) begin
         phase <= 3'h0;
      end else if (dl.cpu_tick) begin
         if (phase == 3'(ckc_pkg::CKC_OUT_RATIO - 1)) begin
            phase <= 3'h0;
         end else begin
            phase <= phase + 3'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dl.clkout <= 1'b0;
      end else if (!dl.clkout_en || !dl.running) begin
         dl.clkout <= 1'b0;
      end else if (dl.cpu_tick) begin
         dl.clkout <= (phase < 3'(ckc_pkg::CKC_OUT_RATIO / 2));
      end
   end
endmodule
`default_nettype wire

// >>> logic/ckc_clock_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
//Behaviour
//- source fixed by configuration input
//- RC source divisible via divider
//- external mode frees second pin while clock output is disabled
//- clock output only RC or external
//- output runs whenever oscillator runs
//- output is CPU clock over six
//- divider zero or 2*(N+1)
//- wake wait 1024 or 256 clocks
//- divider changes without stalling
module ckc_clock_ctrl (
   // System
   input  wire logic       clk,
   input  wire logic       reset,
   // Configuration and wake
   input  wire logic [2:0] osc_source,
   input  wire logic       wake_event,
   // AHB-Lite slave
   input  wire logic       hsel,
   input  wire logic [7:0] haddr,
   input  wire logic [1:0] htrans,
   input  wire logic       hwrite,
   input  wire logic [2:0] hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic       hready,
   output logic [31:0]     hrdata,
   output logic            hreadyout,
   output logic            hresp,
   // Clocking outputs
   output logic            cpu_tick,
   output logic            cpu_run,
   output logic            xtal2_clock_out_pin,
   output logic            xtal2_port_free
);
   ckc_div_if dl ();

   ckc_pkg::ckc_src_t   src;
   ckc_pkg::ckc_state_t state;
   logic [7:0]  cpu_clock_divider;
   logic [7:0]  port2_mode_reg1;
   logic        compat_half;
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic [8:0]  div_cnt;
   logic [10:0] stable_cnt;
   logic        src_latched;
   logic        next_tick;

   function automatic logic is_crystal(input ckc_pkg::ckc_src_t s);
      return s == ckc_pkg::CKC_SRC_XTAL_LOW || s == ckc_pkg::CKC_SRC_XTAL_MED
          || s == ckc_pkg::CKC_SRC_XTAL_HIGH;
   endfunction

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         src         <= ckc_pkg::CKC_SRC_RC;
         src_latched <= 1'b0;
      end else if (!src_latched) begin
         src         <= ckc_pkg::ckc_src_t'(osc_source);
         src_latched <= 1'b1;
      end
   end

   // AHB-Lite address phase capture, zero wait states
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= haddr;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpu_clock_divider <= ckc_pkg::CKC_DIVIDER_RST;
         port2_mode_reg1   <= ckc_pkg::CKC_PORT2M1_RST;
         compat_half       <= 1'b0;
      end else if (wr_pend) begin
         unique case (wr_addr)
            ckc_pkg::CKC_ADDR_DIVIDER: cpu_clock_divider <= hwdata[7:0];
            ckc_pkg::CKC_ADDR_PORT2M1:
               port2_mode_reg1 <= hwdata[7:0] & ckc_pkg::CKC_PORT2M1_MASK;
            ckc_pkg::CKC_ADDR_CONTROL:
               compat_half <= hwdata[ckc_pkg::CKC_COMPAT_BIT];
            default: ;
         endcase
      end
   end

   // Read data for the data phase
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hrdata <= 32'h0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         unique case (haddr)
            ckc_pkg::CKC_ADDR_DIVIDER: hrdata <= {24'h0, cpu_clock_divider};
            ckc_pkg::CKC_ADDR_PORT2M1: hrdata <= {24'h0, port2_mode_reg1};
            ckc_pkg::CKC_ADDR_CONTROL: hrdata <= {30'h0, compat_half, 1'b0};
            ckc_pkg::CKC_ADDR_STATUS:
               hrdata <= {26'h0, cpu_run, state, src};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Power Down entry, wake and stability wait
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ckc_pkg::CKC_ST_RUN;
      end else begin
         unique case (state)
            ckc_pkg::CKC_ST_RUN:
               if (wr_pend && wr_addr == ckc_pkg::CKC_ADDR_CONTROL
                   && hwdata[ckc_pkg::CKC_PD_BIT])
                  state <= ckc_pkg::CKC_ST_DOWN;
            ckc_pkg::CKC_ST_DOWN:
               if (wake_event) state <= ckc_pkg::CKC_ST_WAIT;
            ckc_pkg::CKC_ST_WAIT:
               if (stable_cnt == 11'h1 && next_tick)
                  state <= ckc_pkg::CKC_ST_RUN;
            default: state <= ckc_pkg::CKC_ST_RUN;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stable_cnt <= 11'h0;
      end else if (state == ckc_pkg::CKC_ST_DOWN) begin
         stable_cnt <= is_crystal(src) ? 11'(ckc_pkg::CKC_STABLE_XTAL)
                                       : 11'(ckc_pkg::CKC_STABLE_RC);
      end else if (state == ckc_pkg::CKC_ST_WAIT && next_tick) begin
         stable_cnt <= stable_cnt - 11'h1;
      end
   end

   always_comb begin
      if (cpu_clock_divider != 8'h00) begin
         next_tick = (div_cnt >= {cpu_clock_divider, 1'b1});
      end else if (compat_half) begin
         next_tick = div_cnt[0];
      end else begin
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_cnt <= 9'h0;
      end else if (state == ckc_pkg::CKC_ST_DOWN || next_tick) begin
         div_cnt <= 9'h0;
      end else begin
         div_cnt <= div_cnt + 9'h1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpu_tick <= 1'b0;
         cpu_run  <= 1'b0;
      end else begin
         cpu_tick <= next_tick && state != ckc_pkg::CKC_ST_DOWN;
         cpu_run  <= state == ckc_pkg::CKC_ST_RUN;
      end
   end

   assign dl.cpu_tick  = next_tick;
   assign dl.running   = state != ckc_pkg::CKC_ST_DOWN;
   assign dl.clkout_en = port2_mode_reg1[ckc_pkg::CKC_CLKOUT_EN_BIT]
                         && !is_crystal(src);

   ckc_out_div u_out (
      .clk   (clk),
      .reset (reset),
      .dl    (dl)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         xtal2_clock_out_pin <= 1'b0;
         xtal2_port_free     <= 1'b0;
      end else begin
         xtal2_clock_out_pin <= dl.clkout;
         xtal2_port_free     <= src == ckc_pkg::CKC_SRC_EXT && !dl.clkout_en;
      end
   end

   // Assertions
   sequence s_down_two;
      state == ckc_pkg::CKC_ST_DOWN ##1 state == ckc_pkg::CKC_ST_DOWN;
   endsequence
   sequence s_wake_fast;
      $rose(state == ckc_pkg::CKC_ST_WAIT) && !is_crystal(src)
      && cpu_clock_divider == 8'h00 && !compat_half;
   endsequence
   sequence s_wait_256;
      ##255 state == ckc_pkg::CKC_ST_WAIT
      ##1 state == ckc_pkg::CKC_ST_RUN;
   endsequence

   a_out_crystal_off: assert property (
      @(posedge clk) disable iff (reset)
      is_crystal(src) |-> ##2 !xtal2_clock_out_pin)
      else $error("clock output active with crystal source");
   // Pin trails the divider by one register, so look two edges on
   a_down_static: assert property (
      @(posedge clk) disable iff (reset)
      s_down_two |-> ##2 $stable(xtal2_clock_out_pin))
      else $error("clock output toggles in power down");
   a_src_fixed: assert property (
      @(posedge clk) disable iff (reset)
      src_latched |=> $stable(src))
      else $error("clock source changed at run time");
   a_tick_undiv: assert property (
      @(posedge clk) disable iff (reset)
      cpu_clock_divider == 8'h00 && !compat_half
      && state != ckc_pkg::CKC_ST_DOWN |=> cpu_tick)
      else $error("undivided tick missing");
   a_port_free: assert property (
      @(posedge clk) disable iff (reset)
      src == ckc_pkg::CKC_SRC_EXT && !dl.clkout_en |=> xtal2_port_free)
      else $error("port pin not released");
   a_wait_len: assert property (
      @(posedge clk) disable iff (reset)
      s_wake_fast |-> s_wait_256)
      else $error("wake stability count wrong");
   a_div_write: assert property (
      @(posedge clk) disable iff (reset)
      wr_pend && wr_addr == ckc_pkg::CKC_ADDR_DIVIDER
      |=> cpu_clock_divider == $past(hwdata[7:0]))
      else $error("divider write lost");
   // Undivided ticks: output level flips every three clocks
   a_out_enabled: assert property (
      @(posedge clk) disable iff (reset)
      (dl.clkout_en && dl.running && cpu_clock_divider == 8'h00
      && !compat_half) [*4] |-> dl.clkout != $past(dl.clkout, 3))
      else $error("clock output idle while enabled");
endmodule
`default_nettype wire

// >>> tb/ckc_sync_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Outside device locking onto the clock output; it measures the period
module ckc_sync_dev (
   // System
   input  wire logic clk,
   input  wire logic reset,
   // Observed clock
   input  wire logic sync_clk,
   output int        period,
   output int        rises
);
   int   cnt;
   logic last;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 0;
         last <= 1'b0;
         period <= 0;
         rises <= 0;
      end else begin
         last <= sync_clk;
         cnt <= (sync_clk && !last) ? 1 : cnt + 1;
         if (sync_clk && !last) begin
            period <= cnt;
            rises <= rises + 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  osc_source = 3'h3;
   logic        wake_event = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, d;
   logic        hreadyout, hresp, cpu_tick, cpu_run, pin, port_free;
   logic        rd_pend = 1'b0;
   logic [7:0]  dv[4] = '{8'h00, 8'h01, 8'h02, 8'hff};
   logic [31:0] exp_q[$];
   int          period, rises, r0, n, num_errors = 0, check_count = 0;
   always #2.5 clk = ~clk;
   ckc_clock_ctrl uut (.clk(clk), .reset(reset), .osc_source(osc_source),
      .wake_event(wake_event), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cpu_tick(cpu_tick), .cpu_run(cpu_run),
      .xtal2_clock_out_pin(pin), .xtal2_port_free(port_free));
   ckc_sync_dev dev (.clk(clk), .reset(reset), .sync_clk(pin),
      .period(period), .rises(rises));
   task automatic summarize;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic lim(input int top);
      if (n >= top) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic wait_rdy;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      lim(64);
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_rdy();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wait_rises(input int k);
      r0 = rises;
      n = 0;
      while (rises < r0 + k && n < 20000) begin
         @(posedge clk);
         n++;
      end
      lim(20000);
   endtask
   // Read data is taken at the edge that ends the data phase
   always @(posedge clk) begin
      if (rd_pend) begin
         check("hrdata", hrdata, exp_q.pop_front());
         check("hresp", {31'h0, hresp}, 32'h0);
      end
      rd_pend = hsel && htrans[1] && !hwrite && hreadyout;
   end
   initial begin
      void'($urandom(32'h3f44));
      dv[2] = 8'h02 + 8'($urandom % 8);
      // Every source code in turn; bench clock stands for crystal or input
      for (int s = 0; s < 5; s++) begin
         osc_source <= 3'(s);
         reset <= 1'b1;
         repeat (4) @(posedge clk);
         reset <= 1'b0;
         // Source latch and status need one edge before the first read
         repeat (2) @(posedge clk);
         rd(8'h0c, {26'h0, 1'b1, ckc_pkg::CKC_ST_RUN, 3'(s)});
         osc_source <= 3'((s + 1) % 5);
         bus(1'b1, ckc_pkg::CKC_ADDR_PORT2M1, 32'h10);
         rd(8'h0c, {26'h0, 1'b1, ckc_pkg::CKC_ST_RUN, 3'(s)});
         r0 = rises;
         repeat (40) @(posedge clk);
         check("clkout", 32'(rises > r0), 32'(s > 2));
         check("port_free on", {31'h0, port_free}, 32'h0);
         // Enable dropped before going quiet, as software should
         bus(1'b1, ckc_pkg::CKC_ADDR_PORT2M1, 32'h0);
         repeat (20) @(posedge clk);
         check("port_free", {31'h0, port_free}, {31'h0, s == 4});
         check("pin off", {31'h0, pin}, 32'h0);
      end
      rd(ckc_pkg::CKC_ADDR_DIVIDER, 32'(ckc_pkg::CKC_DIVIDER_RST));
      d = $urandom | 32'h10;
      bus(1'b1, ckc_pkg::CKC_ADDR_PORT2M1, d);
      rd(ckc_pkg::CKC_ADDR_PORT2M1, d & 32'(ckc_pkg::CKC_PORT2M1_MASK));
      bus(1'b1, 8'h10, d);
      rd(8'h10, 32'h0);
      foreach (dv[i]) begin
         bus(1'b1, ckc_pkg::CKC_ADDR_DIVIDER, {24'h0, dv[i]});
         rd(ckc_pkg::CKC_ADDR_DIVIDER, {24'h0, dv[i]});
         wait_rises(3);
         check("period", period, dv[i] == 0 ? 6 : 12 * (dv[i] + 1));
         check("run", {31'h0, cpu_run}, 32'h1);
      end
      bus(1'b1, ckc_pkg::CKC_ADDR_DIVIDER, 32'h0);
      bus(1'b1, ckc_pkg::CKC_ADDR_CONTROL, 32'h2);
      wait_rises(3);
      check("half rate", period, 12);
      n = 0;
      repeat (12) begin
         @(posedge clk);
         n += int'(cpu_tick);
      end
      check("ticks", n, 6);
      bus(1'b1, ckc_pkg::CKC_ADDR_CONTROL, 32'h1);
      repeat (10) @(posedge clk);
      check("down run", {31'h0, cpu_run}, 32'h0);
      check("down pin", {31'h0, pin}, 32'h0);
      wake_event <= 1'b1;
      n = 0;
      while (cpu_run !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      lim(2000);
      wake_event <= 1'b0;
      check("wake wait", 32'(n >= 256 && n <= 264), 32'h1);
      wait_rises(3);
      check("restart", period, 6);
      summarize();
   end
endmodule
`default_nettype wire
